// *** hpreg_consts.vh ***
// constants for the headphone amplifier serial control register bank
`ifndef HPREG_CONSTS_VH
`define HPREG_CONSTS_VH

// bus addresses and command
`define HPREG_SLAVE_ADDR      7'h60
`define HPREG_GC_ADDR         8'h00
`define HPREG_GC_RESET_CMD    8'h06

// register pointer locations
`define HPREG_PTR_EMPTY0      3'h0
`define HPREG_PTR_MODE        3'h1
`define HPREG_PTR_VOLUME      3'h2
`define HPREG_PTR_FLOAT       3'h3
`define HPREG_PTR_IDENT       3'h4
`define HPREG_PTR_EMPTY5      3'h5
`define HPREG_PTR_TEST        3'h6
`define HPREG_PTR_EMPTY7      3'h7

// mode_control fields
`define HPREG_MODE_LEFT_ON    7
`define HPREG_MODE_RIGHT_ON   6
`define HPREG_MODE_THERMAL    1
`define HPREG_MODE_SHUTDOWN   0

// volume_mute fields
`define HPREG_VOL_LEFT_SIL    7
`define HPREG_VOL_RIGHT_SIL   6
`define HPREG_VOL_GAIN_HI     5
`define HPREG_VOL_GAIN_LO     1

// output_float fields
`define HPREG_FLOAT_LEFT      1
`define HPREG_FLOAT_RIGHT     0

// reset values
`define HPREG_RST_CHAN_ON     1'b0
`define HPREG_RST_SHUTDOWN    1'b0
`define HPREG_RST_SILENCE     1'b1
`define HPREG_RST_GAIN        5'h00
`define HPREG_RST_FLOAT       1'b0
`define HPREG_RST_TEST        8'h00
`define HPREG_RST_PTR         3'h0

// timing
`define HPREG_CLK_PERIOD_NS   10
`define HPREG_STEP_TIME_NS    1000000
`define HPREG_STEP_CYCLES     (`HPREG_STEP_TIME_NS / `HPREG_CLK_PERIOD_NS)

`endif

// *** hpreg_ramp.v ***
// per-channel gain stepper toward the programmed volume and mute
`timescale 1ns/100ps
`include "hpreg_consts.vh"

module hpreg_ramp #(
  parameter STEP_CYCLES = `HPREG_STEP_CYCLES,
  parameter CHANNELS    = 2
) (
  input  wire                  i_clock,
  input  wire                  i_reset,
  input  wire                  i_clear,
  input  wire [CHANNELS-1:0]   i_silence,
  input  wire [5*CHANNELS-1:0] i_gain,
  output reg  [5*CHANNELS-1:0] o_gain,
  output reg  [CHANNELS-1:0]   o_muted
);

  localparam CNT_W = $clog2(STEP_CYCLES + 1);
  localparam [31:0]      LAST_FULL = STEP_CYCLES - 1;
  localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];

  reg [CNT_W-1:0] tick_count;
  reg             tick;

  // one shared step tick keeps both channels in lock step
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      tick_count <= {CNT_W{1'b0}};
      tick       <= 1'b0;
    end
    else if (i_clear || tick_count == LAST)
    begin
      tick_count <= {CNT_W{1'b0}};
      tick       <= ~i_clear;
    end
    else
    begin
      tick_count <= tick_count + {{(CNT_W-1){1'b0}}, 1'b1};
      tick       <= 1'b0;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      wire [4:0] target = i_gain[5*ch +: 5];
      wire [4:0] level  = o_gain[5*ch +: 5];
      // a silenced channel mutes only after gain has walked down to the bottom, avoids clicks
      always @(posedge i_clock or posedge i_reset)
      begin
        if (i_reset)
        begin
          o_gain[5*ch +: 5] <= `HPREG_RST_GAIN;
          o_muted[ch]       <= `HPREG_RST_SILENCE;
        end
        else if (i_clear)
        begin
          o_gain[5*ch +: 5] <= `HPREG_RST_GAIN;
          o_muted[ch]       <= `HPREG_RST_SILENCE;
        end
        else if (tick)
        begin
          if (i_silence[ch])
          begin
            if (level != 5'h00)
              o_gain[5*ch +: 5] <= level - 5'h01;
            else
              o_muted[ch] <= 1'b1;
          end
          else if (o_muted[ch])
            o_muted[ch] <= 1'b0;
          else if (level < target)
            o_gain[5*ch +: 5] <= level + 5'h01;
          else if (level > target)
            o_gain[5*ch +: 5] <= level - 5'h01;
        end
      end
    end
  endgenerate

endmodule // hpreg_ramp

// *** hpreg_ctrl.v ***
// serial-bus slave and control registers of the stereo headphone amplifier
//
// Summary of operation
// - answer slave address 1100000 plus direction bit
// - address lsb one reads, zero writes
// - general-call reset acked, restores power-on values
// - first written byte loads register pointer
// - only pointer bits 2:0 are used
// - locations 0, 5, 7 are not acknowledged
// - mode bits 7/6 enable left/right, default off
// - mode bits 5:2 read as zero
// - mode bit 1 shows thermal shutdown
// - mode bit 0 software shutdown, default zero
// - volume bits 7/6 mute left/right, default set
// - volume bits 5:1 hold gain code, default zero
// - volume bit 0 reads zero
// - float bits 7:2 read zero
// - float bits 1/0 float left/right outputs
// - location 4 reads identity and version
// - location 6 is read/write test register
// - gain steps once per millisecond toward target
// - identity: supplier 7:6, zeros 5:4, version 3:0
`timescale 1ns/100ps
`include "hpreg_consts.vh"

module hpreg_ctrl #(
  parameter       STEP_CYCLES   = `HPREG_STEP_CYCLES,
  parameter [1:0] SUPPLIER_CODE = 2'h1, // arbitrary value
  parameter [3:0] VERSION_CODE  = 4'h0
) (
  input  wire       i_clock,
  input  wire       i_reset,
  input  wire       i_scl,
  input  wire       i_sda_in,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  input  wire       i_thermal_alarm,
  output reg        o_left_channel_on,
  output reg        o_right_channel_on,
  output reg        o_soft_shutdown,
  output reg        o_left_float,
  output reg        o_right_float,
  output reg  [7:0] o_factory_test,
  output wire [4:0] o_left_gain,
  output wire [4:0] o_right_gain,
  output wire       o_left_muted,
  output wire       o_right_muted
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_PTR    = 3'h2;
  localparam [2:0] ST_WDATA  = 3'h3;
  localparam [2:0] ST_GCCMD  = 3'h4;
  localparam [2:0] ST_RDATA  = 3'h5;
  localparam [2:0] ST_IGNORE = 3'h6;

  // pin synchronisers
  reg       scl_meta;
  reg       scl_sync;
  reg       scl_last;
  reg       sda_meta;
  reg       sda_sync;
  reg       sda_last;
  reg       therm_meta;
  reg       therm_sync;

  // bus engine
  reg [2:0] state;
  reg [2:0] after_ack;
  reg [3:0] bit_count;
  reg [7:0] rx_byte;
  reg [7:0] tx_byte;
  reg       gc_clear;

  // registers
  reg [2:0] pointer;
  reg       left_silence;
  reg       right_silence;
  reg [4:0] gain_code;

  reg [7:0] read_data;
  reg       ptr_valid;
  reg       rx_ptr_valid;

  wire scl_rise  = scl_sync & ~scl_last;
  wire scl_fall  = ~scl_sync & scl_last;
  wire bus_start = scl_sync & scl_last & sda_last & ~sda_sync;
  wire bus_stop  = scl_sync & scl_last & ~sda_last & sda_sync;
  wire byte_end  = scl_fall && bit_count == 4'h8;
  wire ack_end   = scl_fall && bit_count == 4'h9;
  wire wr_strobe = state == ST_WDATA && byte_end && ptr_valid;

  // first stage feeds only the second; edges are found one stage later
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_meta   <= 1'b1;
      scl_sync   <= 1'b1;
      scl_last   <= 1'b1;
      sda_meta   <= 1'b1;
      sda_sync   <= 1'b1;
      sda_last   <= 1'b1;
      therm_meta <= 1'b0;
      therm_sync <= 1'b0;
    end
    else
    begin
      scl_meta   <= i_scl;
      scl_sync   <= scl_meta;
      scl_last   <= scl_sync;
      sda_meta   <= i_sda_in;
      sda_sync   <= sda_meta;
      sda_last   <= sda_sync;
      therm_meta <= i_thermal_alarm;
      therm_sync <= therm_meta;
    end
  end

  // empty locations are refused
  always @*
  begin
    ptr_valid = 1'b1;
    case (pointer)
      `HPREG_PTR_EMPTY0: ptr_valid = 1'b0;
      `HPREG_PTR_EMPTY5: ptr_valid = 1'b0;
      `HPREG_PTR_EMPTY7: ptr_valid = 1'b0;
      default:           ptr_valid = 1'b1;
    endcase
  end

  always @*
  begin
    rx_ptr_valid = 1'b1;
    case (rx_byte[2:0])
      `HPREG_PTR_EMPTY0: rx_ptr_valid = 1'b0;
      `HPREG_PTR_EMPTY5: rx_ptr_valid = 1'b0;
      `HPREG_PTR_EMPTY7: rx_ptr_valid = 1'b0;
      default:           rx_ptr_valid = 1'b1;
    endcase
  end

  // read-back of the location selected by the pointer
  always @*
  begin
    read_data = 8'h00;
    case (pointer)
      `HPREG_PTR_MODE:
      begin
        read_data[`HPREG_MODE_LEFT_ON]  = o_left_channel_on;
        read_data[`HPREG_MODE_RIGHT_ON] = o_right_channel_on;
        read_data[`HPREG_MODE_THERMAL]  = therm_sync;
        read_data[`HPREG_MODE_SHUTDOWN] = o_soft_shutdown;
      end
      `HPREG_PTR_VOLUME:
      begin
        read_data[`HPREG_VOL_LEFT_SIL]  = left_silence;
        read_data[`HPREG_VOL_RIGHT_SIL] = right_silence;
        read_data[`HPREG_VOL_GAIN_HI:`HPREG_VOL_GAIN_LO] = gain_code;
      end
      `HPREG_PTR_FLOAT:
      begin
        read_data[`HPREG_FLOAT_LEFT]  = o_left_float;
        read_data[`HPREG_FLOAT_RIGHT] = o_right_float;
      end
      `HPREG_PTR_IDENT:
        read_data = {SUPPLIER_CODE, 2'h0, VERSION_CODE};
      `HPREG_PTR_TEST:
        read_data = o_factory_test;
      default:
        read_data = 8'h00;
    endcase
    // unlisted bits stay zero
  end

  // bus engine: sample on scl rise, change sda on scl fall
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state     <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_count <= 4'h0;
      rx_byte   <= 8'h00;
      tx_byte   <= 8'h00;
      gc_clear  <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
    end
    else
    begin
      gc_clear  <= 1'b0;
      o_sda_out <= 1'b0;
      if (bus_start)
      begin
        state     <= ST_ADDR;
        bit_count <= 4'h0;
        o_sda_oe  <= 1'b0;
      end
      else if (bus_stop)
      begin
        state     <= ST_IDLE;
        bit_count <= 4'h0;
        o_sda_oe  <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA, ST_GCCMD:
          begin
            if (scl_rise && bit_count < 4'h8)
            begin
              rx_byte   <= {rx_byte[6:0], sda_sync};
              bit_count <= bit_count + 4'h1;
            end
            else if (byte_end)
            begin
              bit_count <= 4'h9;
              after_ack <= ST_IGNORE;
              o_sda_oe  <= 1'b0;
              case (state)
                ST_ADDR:
                begin
                  if (rx_byte[7:1] == `HPREG_SLAVE_ADDR)
                  begin
                    if (rx_byte[0])
                    begin
                      // a read from an empty location is refused here
                      o_sda_oe  <= ptr_valid;
                      after_ack <= ptr_valid ? ST_RDATA : ST_IGNORE;
                    end
                    else
                    begin
                      o_sda_oe  <= 1'b1;
                      after_ack <= ST_PTR;
                    end
                  end
                  else if (rx_byte == `HPREG_GC_ADDR)
                  begin
                    o_sda_oe  <= 1'b1;
                    after_ack <= ST_GCCMD;
                  end
                end
                ST_PTR:
                begin
                  o_sda_oe  <= rx_ptr_valid;
                  after_ack <= ST_WDATA;
                end
                ST_WDATA:
                begin
                  o_sda_oe  <= ptr_valid;
                  after_ack <= ST_WDATA;
                end
                ST_GCCMD:
                begin
                  if (rx_byte == `HPREG_GC_RESET_CMD)
                  begin
                    o_sda_oe <= 1'b1;
                    gc_clear <= 1'b1;
                  end
                end
                default:
                  after_ack <= ST_IGNORE;
              endcase
            end
            else if (ack_end)
            begin
              bit_count <= 4'h0;
              state     <= after_ack;
              o_sda_oe  <= 1'b0;
              if (after_ack == ST_RDATA)
              begin
                tx_byte  <= read_data;
                o_sda_oe <= ~read_data[7];
              end
            end
          end
          ST_RDATA:
          begin
            if (scl_rise && bit_count < 4'h8)
              bit_count <= bit_count + 4'h1;
            else if (scl_rise)
            begin
              // master ack asks for another byte; nack ends our drive
              if (!sda_sync)
              begin
                bit_count <= 4'h0;
                tx_byte   <= read_data;
              end
              else
                state <= ST_IGNORE;
            end
            else if (scl_fall && bit_count < 4'h8)
              o_sda_oe <= ~tx_byte[3'h7 - bit_count[2:0]];
            else if (byte_end)
              o_sda_oe <= 1'b0;
          end
          ST_IGNORE:
            o_sda_oe <= 1'b0;
          ST_IDLE:
            o_sda_oe <= 1'b0;
          default:
          begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // register file; general-call reset returns every field to power-on value
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      pointer            <= `HPREG_RST_PTR;
      o_left_channel_on  <= `HPREG_RST_CHAN_ON;
      o_right_channel_on <= `HPREG_RST_CHAN_ON;
      o_soft_shutdown    <= `HPREG_RST_SHUTDOWN;
      left_silence       <= `HPREG_RST_SILENCE;
      right_silence      <= `HPREG_RST_SILENCE;
      gain_code          <= `HPREG_RST_GAIN;
      o_left_float       <= `HPREG_RST_FLOAT;
      o_right_float      <= `HPREG_RST_FLOAT;
      o_factory_test     <= `HPREG_RST_TEST;
    end
    else if (gc_clear)
    begin
      pointer            <= `HPREG_RST_PTR;
      o_left_channel_on  <= `HPREG_RST_CHAN_ON;
      o_right_channel_on <= `HPREG_RST_CHAN_ON;
      o_soft_shutdown    <= `HPREG_RST_SHUTDOWN;
      left_silence       <= `HPREG_RST_SILENCE;
      right_silence      <= `HPREG_RST_SILENCE;
      gain_code          <= `HPREG_RST_GAIN;
      o_left_float       <= `HPREG_RST_FLOAT;
      o_right_float      <= `HPREG_RST_FLOAT;
      o_factory_test     <= `HPREG_RST_TEST;
    end
    else if (state == ST_PTR && byte_end)
      pointer <= rx_byte[2:0];
    else if (wr_strobe)
    begin
      case (pointer)
        `HPREG_PTR_MODE:
        begin
          o_left_channel_on  <= rx_byte[`HPREG_MODE_LEFT_ON];
          o_right_channel_on <= rx_byte[`HPREG_MODE_RIGHT_ON];
          o_soft_shutdown    <= rx_byte[`HPREG_MODE_SHUTDOWN];
        end
        `HPREG_PTR_VOLUME:
        begin
          left_silence  <= rx_byte[`HPREG_VOL_LEFT_SIL];
          right_silence <= rx_byte[`HPREG_VOL_RIGHT_SIL];
          gain_code     <= rx_byte[`HPREG_VOL_GAIN_HI:`HPREG_VOL_GAIN_LO];
        end
        `HPREG_PTR_FLOAT:
        begin
          o_left_float  <= rx_byte[`HPREG_FLOAT_LEFT];
          o_right_float <= rx_byte[`HPREG_FLOAT_RIGHT];
        end
        `HPREG_PTR_TEST:
          o_factory_test <= rx_byte;
        default:
          o_factory_test <= o_factory_test;
      endcase
    end
  end

  // left channel sits in the upper slice
  hpreg_ramp #(
    .STEP_CYCLES (STEP_CYCLES),
    .CHANNELS    (2)
  ) u_ramp (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_clear   (gc_clear),
    .i_silence ({left_silence, right_silence}),
    .i_gain    ({gain_code, gain_code}),
    .o_gain    ({o_left_gain, o_right_gain}),
    .o_muted   ({o_left_muted, o_right_muted})
  );

endmodule // hpreg_ctrl

// *** hpreg_ctrl_sva.sv ***
// assertions on the pins of the amplifier control register bank
`timescale 1ns/100ps
module hpreg_ctrl_sva #(
  parameter STEP_CYCLES = 20
) (
  input wire       i_clock,
  input wire       i_reset,
  input wire       i_scl,
  input wire       o_sda_out,
  input wire       o_sda_oe,
  input wire [4:0] o_left_gain,
  input wire [4:0] o_right_gain,
  input wire       o_left_muted,
  input wire       o_right_muted
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // needs STEP_CYCLES above 8; a bus clear may cut a quiet stretch short
  sequence l_quiet_s;
    $stable(o_left_gain) [*8];
  endsequence
  sequence r_quiet_s;
    $stable(o_right_gain) [*8];
  endsequence
  open_drain_a: assert property (o_sda_out == 1'b0)
    else $error("sda driven high");
  oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("sda drive moved while scl high");
  l_step_a: assert property ($changed(o_left_gain) |->
    o_left_gain == $past(o_left_gain) + 5'h01 || o_left_gain == $past(o_left_gain) - 5'h01
    || (o_left_gain == 5'h00 && $rose(o_left_muted))) else $error("left gain jumped");
  r_step_a: assert property ($changed(o_right_gain) |->
    o_right_gain == $past(o_right_gain) + 5'h01 || o_right_gain == $past(o_right_gain) - 5'h01
    || (o_right_gain == 5'h00 && $rose(o_right_muted))) else $error("right gain jumped");
  l_hold_a: assert property ($changed(o_left_gain) |=> l_quiet_s)
    else $error("left gain stepped too soon");
  r_hold_a: assert property ($changed(o_right_gain) |=> r_quiet_s)
    else $error("right gain stepped too soon");
  l_mute_zero_a: assert property (o_left_muted |-> o_left_gain == 5'h00)
    else $error("left muted with gain");
  r_mute_zero_a: assert property (o_right_muted |-> o_right_gain == 5'h00)
    else $error("right muted with gain");
  l_climb_a: assert property ($changed(o_left_gain) && $past(o_left_gain) == 5'h00
    |-> !$past(o_left_muted)) else $error("left climbed while muted");
  r_climb_a: assert property ($changed(o_right_gain) && $past(o_right_gain) == 5'h00
    |-> !$past(o_right_muted)) else $error("right climbed while muted");
  // steps only on the shared tick; a bus clear (gain to zero with mute) is exempt
  reg [4:0] l_prev;
  reg [4:0] r_prev;
  integer   l_since;
  integer   r_since;
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      l_prev  <= 5'h00;
      r_prev  <= 5'h00;
      l_since <= 0;
      r_since <= 0;
    end
    else
    begin
      l_prev  <= o_left_gain;
      r_prev  <= o_right_gain;
      l_since <= (o_left_gain != l_prev) ? 0 : l_since + 1;
      r_since <= (o_right_gain != r_prev) ? 0 : r_since + 1;
    end
  end
  l_pace_a: assert property (o_left_gain != l_prev && !o_left_muted |->
    l_since >= STEP_CYCLES - 1) else $error("left gain steps too close");
  r_pace_a: assert property (o_right_gain != r_prev && !o_right_muted |->
    r_since >= STEP_CYCLES - 1) else $error("right gain steps too close");
endmodule // hpreg_ctrl_sva

bind hpreg_ctrl hpreg_ctrl_sva #(.STEP_CYCLES(STEP_CYCLES)) sva_u (
  .i_clock(i_clock), .i_reset(i_reset), .i_scl(i_scl), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_left_gain(o_left_gain), .o_right_gain(o_right_gain),
  .o_left_muted(o_left_muted), .o_right_muted(o_right_muted));

// *** hpreg_master.sv ***
// serial bus master model driving scl and its share of sda
`timescale 1ns/100ps
module hpreg_master (
  input  wire i_clock,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task tick(input integer n);
    repeat (n) @(negedge i_clock);
  endtask
  // extra low time lets the slave let go of sda before the start
  task start;
    begin
      tick(3);
      o_sda = 1'b1;
      tick(3);
      o_scl = 1'b1;
      tick(4);
      o_sda = 1'b0;
      tick(4);
      o_scl = 1'b0;
    end
  endtask
  task stop;
    begin
      tick(3);
      o_sda = 1'b0;
      tick(3);
      o_scl = 1'b1;
      tick(4);
      o_sda = 1'b1;
      tick(4);
    end
  endtask
  // 80 ns per bit: sda moves only mid low phase, sampled at end of high
  task bit_x(input b, output r);
    begin
      tick(2);
      o_sda = b;
      tick(2);
      o_scl = 1'b1;
      tick(4);
      r = i_sda;
      o_scl = 1'b0;
    end
  endtask
  task wbyte(input [7:0] d, output a);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_x(d[k], r);
      bit_x(1'b1, r);
      a = ~r;
    end
  endtask
  task rbyte(input nack, output [7:0] d);
    integer k;
    reg     r;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        bit_x(1'b1, r);
        d = {d[6:0], r};
      end
      bit_x(nack, r);
    end
  endtask
endmodule // hpreg_master

// *** hpreg_ctrl_tb.sv ***
// self-checking bench for the amplifier control register bank
`timescale 1ns/100ps
module hpreg_ctrl_tb;
  localparam        STEP = 20;
  localparam [39:0] PTR  = 40'h0102030406;
  localparam [39:0] RST  = 40'h00C0004000; // supplier field arbitrary
  reg        i_clock;
  reg        i_reset;
  reg        i_thermal_alarm;
  wire       scl, m_sda, sda, sda_out, sda_oe;
  wire       l_on, r_on, soft_shutdown, l_fl, r_fl, lm, rm;
  wire [7:0] t_reg;
  wire [4:0] lg, rg;
  reg  [7:0] exp_q[$];
  reg  [7:0] got_q[$];
  reg  [7:0] d;
  reg        a;
  integer    i, seed, failures, n_checks;
  assign sda = (sda_oe ? sda_out : 1'b1) & m_sda;
  hpreg_ctrl #(.STEP_CYCLES(STEP), .SUPPLIER_CODE(2'h1), .VERSION_CODE(4'h0)) dut_u (
    .i_clock(i_clock), .i_reset(i_reset),
    .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_thermal_alarm(i_thermal_alarm), .o_left_channel_on(l_on),
    .o_right_channel_on(r_on), .o_soft_shutdown(soft_shutdown), .o_left_float(l_fl),
    .o_right_float(r_fl), .o_factory_test(t_reg), .o_left_gain(lg), .o_right_gain(rg),
    .o_left_muted(lm), .o_right_muted(rm));
  hpreg_master partner_u (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task chk(input [7:0] e, input [7:0] g);
    begin
      exp_q.push_back(e);
      got_q.push_back(g);
    end
  endtask
  always @(negedge i_clock)
    while (got_q.size() > 0)
    begin
      n_checks = n_checks + 1;
      if (got_q[0] !== exp_q[0])
      begin
        failures = failures + 1;
        $display("BAD %0t got %h want %h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  task acc(input [7:0] p, input pa);
    begin
      partner_u.start;
      partner_u.wbyte(8'hC0, a);
      chk(8'h01, {7'h00, a});
      partner_u.wbyte(p, a);
      chk({7'h00, pa}, {7'h00, a});
    end
  endtask
  task wr(input [7:0] p, input [7:0] v, input pa, input da);
    begin
      acc(p, pa);
      partner_u.wbyte(v, a);
      chk({7'h00, da}, {7'h00, a});
      partner_u.stop;
    end
  endtask
  task rd(input [7:0] p, input [7:0] e);
    reg [7:0] g;
    begin
      acc(p, 1'b1);
      partner_u.start;
      partner_u.wbyte(8'hC1, a);
      chk(8'h01, {7'h00, a});
      partner_u.rbyte(1'b1, g);
      chk(e, g);
      partner_u.stop;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    repeat (40000) @(negedge i_clock);
    failures = failures + 1;
    print_verdict;
  end
  initial
  begin
    seed = 83;
    failures = 0;
    n_checks = 0;
    i_reset = 1'b1;
    i_thermal_alarm = 1'b0;
    repeat (3) @(negedge i_clock);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clock);
    for (i = 0; i < 5; i = i + 1)
      rd(PTR[8*i +: 8], RST[8*i +: 8]);
    partner_u.start;
    partner_u.wbyte(8'hA0, a);
    chk(8'h00, {7'h00, a});
    partner_u.stop;
    for (i = 0; i < 3; i = i + 1)
    begin
      d = $random(seed);
      i_thermal_alarm = i[0];
      wr(8'h01, d, 1'b1, 1'b1);
      rd(8'h01, (d & 8'hC1) | {6'h00, i[0], 1'b0});
      chk({5'h00, d[7], d[6], d[0]}, {5'h00, l_on, r_on, soft_shutdown});
      wr(8'h02, d, 1'b1, 1'b1);
      rd(8'h02, d & 8'hFE);
      wr(8'h03, d, 1'b1, 1'b1);
      rd(8'h03, d & 8'h03);
      chk({6'h00, d[1:0]}, {6'h00, l_fl, r_fl});
      wr(8'hFE, d, 1'b1, 1'b1);
      rd(8'h06, d);
      chk(d, t_reg);
    end
    i_thermal_alarm = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      if (i == 0 || i == 5 || i == 7)
      begin
        wr({5'h15, i[2:0]}, 8'h55, 1'b0, 1'b0);
        partner_u.start;
        partner_u.wbyte(8'hC1, a);
        chk(8'h00, {7'h00, a});
        partner_u.stop;
      end
    wr(8'h02, 8'hC0, 1'b1, 1'b1);
    repeat (40 * STEP) @(negedge i_clock);
    chk(8'hC0, {lm, rm, 1'b0, lg});
    wr(8'h02, 8'h06, 1'b1, 1'b1);
    repeat (10 * STEP) @(negedge i_clock);
    chk(8'h03, {lm, rm, 1'b0, lg});
    chk(8'h03, {3'h0, rg});
    wr(8'h01, 8'hC1, 1'b1, 1'b1);
    wr(8'h03, 8'h03, 1'b1, 1'b1);
    wr(8'h04, 8'hFF, 1'b1, 1'b1);
    rd(8'h04, 8'h40);
    acc(8'h06, 1'b1);
    partner_u.wbyte(8'h5A, a);
    chk(8'h01, {7'h00, a});
    partner_u.wbyte(8'hA5, a);
    chk(8'h01, {7'h00, a});
    partner_u.stop;
    partner_u.start;
    partner_u.wbyte(8'hC1, a);
    chk(8'h01, {7'h00, a});
    partner_u.rbyte(1'b0, d);
    chk(8'hA5, d);
    partner_u.rbyte(1'b1, d);
    chk(8'hA5, d);
    partner_u.stop;
    partner_u.start;
    partner_u.wbyte(8'h00, a);
    chk(8'h01, {7'h00, a});
    partner_u.wbyte(8'h05, a);
    chk(8'h00, {7'h00, a});
    partner_u.stop;
    chk(8'h03, {3'h0, lg});
    partner_u.start;
    partner_u.wbyte(8'h00, a);
    partner_u.wbyte(8'h06, a);
    chk(8'h01, {7'h00, a});
    partner_u.stop;
    chk(8'hC0, {lm, rm, 1'b0, lg});
    chk(8'h00, {5'h00, l_on, r_on, soft_shutdown});
    chk(8'h00, {6'h00, l_fl, r_fl});
    chk(8'h00, t_reg);
    rd(8'h02, 8'hC0);
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h00);
    repeat (2) @(negedge i_clock);
    print_verdict;
  end
endmodule // hpreg_ctrl_tb
